/* File: pkg/pmwc_cfg.svh */
`ifndef PMWC_CFG_SVH
`define PMWC_CFG_SVH
// ****************************************
// wake source bit positions
// ****************************************
`define PMWC_SRC_DIO       0
`define PMWC_SRC_TMR0      1
`define PMWC_SRC_TMR1      2
`define PMWC_SRC_PCNT0     3
`define PMWC_SRC_PCNT1     4
`define PMWC_SRC_COMP      5
`define PMWC_NUM_SRC       6
`define PMWC_DEEP_WAKE_MSK 6'h21
`define PMWC_PEND_RST      6'h00
// ****************************************
// sleep configuration latch fields
// ****************************************
`define PMWC_CFG_RETAIN    0
`define PMWC_CFG_OSC_STOP  1
`define PMWC_CFG_TMR_OFF   2
`define PMWC_CFG_RST       3'h0
// ****************************************
// widths and timing counts
// ****************************************
`define PMWC_TMR_W         41
`define PMWC_PCNT_W        16
`define PMWC_NUM_DIO       8
`define PMWC_PWR_CNT_W     3
`define PMWC_CPU_PWR_CYC   3'h4
`endif

/* File: pkg/pmwc_pkg.sv */
package pmwc_pkg;
  // one-hot controller states
  typedef enum logic [6:0] {
    st_active = 7'h01,
    st_doze   = 7'h02,
    st_sleep  = 7'h04,
    st_deep   = 7'h08,
    st_svm    = 7'h10,
    st_osc    = 7'h20,
    st_cpupwr = 7'h40
  } pmwc_state_t;
endpackage

/* File: verilog/pmwc_wake_timer.sv */
`include "pmwc_cfg.svh"
module pmwc_wake_timer #(
  parameter int W = `PMWC_TMR_W
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         en,
  input  wire logic [W-1:0] cmp,
  output logic      [W-1:0] count_reg,
  output logic              ev_reg
);
  import pmwc_pkg::*;

  logic [W-1:0] count_inc;

  assign count_inc = count_reg + {{(W-1){1'b0}}, 1'b1};

  // free running count, wraps and never stops on a match
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (en && tick) begin
      count_reg <= count_inc;
    end
  end

  // one-cycle event when the count reaches the compare value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev_reg <= 1'b0;
    end else begin
      ev_reg <= en && tick && (count_inc == cmp);
    end
  end

  a_tmr_keeps_run: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (en && tick) |=> (count_reg == $past(count_inc)))
    else $error("wake timer did not advance on tick");
endmodule // pmwc_wake_timer

/* File: verilog/pmwc_pulse_counter.sv */
`include "pmwc_cfg.svh"
module pmwc_pulse_counter #(
  parameter int W = `PMWC_PCNT_W
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         en,
  input  wire logic         debounce_en,
  input  wire logic         pin_s,
  input  wire logic [W-1:0] match,
  output logic      [W-1:0] count_reg,
  output logic              ev_reg
);
  import pmwc_pkg::*;

  logic         deb_a_reg;
  logic         filt_reg;
  logic         lvl_prev_reg;
  logic         lvl;
  logic         pulse;
  logic [W-1:0] count_inc;

  // debounce: accept a level once two slow-clock samples agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deb_a_reg <= 1'b0;
      filt_reg  <= 1'b0;
    end else if (tick) begin
      deb_a_reg <= pin_s;
      if (deb_a_reg == pin_s) begin
        filt_reg <= pin_s;
      end
    end
  end

  // without debounce the pin is used directly, no slow clock needed
  assign lvl       = debounce_en ? filt_reg : pin_s;
  assign pulse     = en && lvl && !lvl_prev_reg;
  assign count_inc = count_reg + {{(W-1){1'b0}}, 1'b1};

  // rising edge detect
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_prev_reg <= 1'b0;
    end else begin
      lvl_prev_reg <= lvl;
    end
  end

  // counting carries on through and after a match
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      ev_reg    <= 1'b0;
    end else begin
      ev_reg <= pulse && (count_inc == match);
      if (pulse) begin
        count_reg <= count_inc;
      end
    end
  end

  a_pcnt_no_loss: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (en && !debounce_en && pin_s && !lvl_prev_reg)
      |=> (count_reg == $past(count_inc)))
    else $error("pulse counter missed a pulse");
endmodule // pmwc_pulse_counter

/* File: verilog/pmwc_top.sv */
`include "pmwc_cfg.svh"
// Function
// - four modes: active, doze, sleep, deep sleep
// - always-on part; timers, oscillator switchable
// - digital domain off during sleep
// - RAM powered in sleep only if retained
// - radio on by baseband, off in sleep
// - doze halts CPU, interrupt resumes it
// - IO levels and pull-ups frozen in sleep
// - stopped slow oscillator restarts on wake
// - sleep ends only on enabled wake source or reset pin
// - pending wake at sleep request rewakes
// - supply, oscillator, CPU power, reset release
// - two 41-bit timers keep counting
// - timers may run in every mode but deep sleep
// - per-pin edge select IO wake
// - IO wake works under alternate functions
// - comparator level change raises wake
// - two 16-bit pulse counters lose none outside deep sleep when debounce is off
// - pulse counters wake without slow oscillator when debounce is off
// - deep sleep stops nearly all functions
// - deep exit by pin or IO/comparator
module pmwc_top #(
  parameter int NUM_DIO = `PMWC_NUM_DIO,
  parameter int TMR_W   = `PMWC_TMR_W,
  parameter int PCNT_W  = `PMWC_PCNT_W
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 external_reset_pin_n,
  input  wire logic                 sleep_req,
  input  wire logic                 deep_sleep_req,
  input  wire logic                 doze_req,
  input  wire logic                 irq_any,
  input  wire logic                 ram_retain_en,
  input  wire logic                 osc_stop_in_sleep,
  input  wire logic                 timers_off_in_sleep,
  input  wire logic                 radio_req,
  input  wire logic                 supply_ok,
  input  wire logic                 hsrc_stable,
  input  wire logic                 osc32k_clk,
  input  wire logic [NUM_DIO-1:0]   digital_io_pins,
  input  wire logic [NUM_DIO-1:0]   dio_wake_en,
  input  wire logic [NUM_DIO-1:0]   dio_wake_rise,
  input  wire logic [NUM_DIO-1:0]   dio_out_core,
  input  wire logic [NUM_DIO-1:0]   dio_pu_core,
  input  wire logic                 comp_in,
  input  wire logic                 comp_wake_en,
  input  wire logic [1:0]           timer_wake_en,
  input  wire logic [TMR_W-1:0]     timer0_cmp,
  input  wire logic [TMR_W-1:0]     timer1_cmp,
  input  wire logic [1:0]           pcnt_in,
  input  wire logic [1:0]           pcnt_wake_en,
  input  wire logic [1:0]           pcnt_debounce_en,
  input  wire logic [PCNT_W-1:0]    pcnt0_match,
  input  wire logic [PCNT_W-1:0]    pcnt1_match,
  input  wire logic [`PMWC_NUM_SRC-1:0] wake_clr,
  output pmwc_pkg::pmwc_state_t     state_reg,
  output logic                      digital_pwr_en_reg,
  output logic                      ram_pwr_en_reg,
  output logic                      radio_pwr_en_reg,
  output logic                      osc32k_run_reg,
  output logic                      timers_pwr_en_reg,
  output logic                      hsrc_en_reg,
  output logic                      cpu_pwr_en_reg,
  output logic                      cpu_reset_n_reg,
  output logic                      cpu_halt_reg,
  output logic                      reset_from_sleep_reg,
  output logic                      io_hold_reg,
  output logic [NUM_DIO-1:0]        dio_out_reg,
  output logic [NUM_DIO-1:0]        dio_pu_reg,
  output logic [`PMWC_NUM_SRC-1:0]  wake_pending_reg,
  output logic [TMR_W-1:0]          timer0_count,
  output logic [TMR_W-1:0]          timer1_count,
  output logic [PCNT_W-1:0]         pcnt0_count,
  output logic [PCNT_W-1:0]         pcnt1_count
);
  import pmwc_pkg::*;

  localparam int SYNC_W = NUM_DIO + 7;

  // ****************************************
  // input synchronisers and edge detect
  // ****************************************
  logic [SYNC_W-1:0]        sync1_reg;
  logic [SYNC_W-1:0]        sync2_reg;
  logic [NUM_DIO-1:0]       dio_prev_reg;
  logic                     comp_prev_reg;
  logic                     osc_prev_reg;
  logic                     edge_arm_reg;
  logic [NUM_DIO-1:0]       dio_s;
  logic                     comp_s;
  logic                     osc_s;
  logic [1:0]               pcnt_s;
  logic                     svm_s;
  logic                     hsrc_s;
  logic                     rst_pin_s;
  logic                     osc_tick;
  logic                     dio_ev;
  logic                     comp_ev;

  // two flops on every pin-side input
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {external_reset_pin_n, hsrc_stable, supply_ok,
                    osc32k_clk, pcnt_in, comp_in, digital_io_pins};
      sync2_reg <= sync1_reg;
    end
  end

  assign dio_s     = sync2_reg[NUM_DIO-1:0];
  assign comp_s    = sync2_reg[NUM_DIO];
  assign pcnt_s    = sync2_reg[NUM_DIO+2:NUM_DIO+1];
  assign osc_s     = sync2_reg[NUM_DIO+3];
  assign svm_s     = sync2_reg[NUM_DIO+4];
  assign hsrc_s    = sync2_reg[NUM_DIO+5];
  assign rst_pin_s = sync2_reg[NUM_DIO+6];

  // previous levels for edge detection; edges are armed only once the
  // synchronisers hold real pin levels, so no false edge after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dio_prev_reg  <= '0;
      comp_prev_reg <= 1'b0;
      osc_prev_reg  <= 1'b0;
      edge_arm_reg  <= 1'b0;
    end else begin
      dio_prev_reg  <= dio_s;
      comp_prev_reg <= comp_s;
      osc_prev_reg  <= osc_s;
      edge_arm_reg  <= rst_pin_s;
    end
  end

  // raw pin level is watched, whatever function owns the pin
  assign dio_ev = edge_arm_reg
                && |(dio_wake_en & ((dio_wake_rise & dio_s & ~dio_prev_reg)
                | (~dio_wake_rise & ~dio_s & dio_prev_reg)));
  assign comp_ev  = edge_arm_reg && (comp_s ^ comp_prev_reg);
  assign osc_tick = osc_s && !osc_prev_reg && osc32k_run_reg;

  // ****************************************
  // timers and pulse counters
  // ****************************************
  logic [1:0] tmr_ev;
  logic [1:0] pc_ev;
  logic       pc_en;

  // timers need only the always-on part; every mode but deep sleep may run them
  pmwc_wake_timer #(.W(TMR_W)) u_tmr0 (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .tick      (osc_tick),
    .en        (timers_pwr_en_reg),
    .cmp       (timer0_cmp),
    .count_reg (timer0_count),
    .ev_reg    (tmr_ev[0])
  );
  pmwc_wake_timer #(.W(TMR_W)) u_tmr1 (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .tick      (osc_tick),
    .en        (timers_pwr_en_reg),
    .cmp       (timer1_cmp),
    .count_reg (timer1_count),
    .ev_reg    (tmr_ev[1])
  );

  assign pc_en = (state_reg != st_deep);

  pmwc_pulse_counter #(.W(PCNT_W)) u_pc0 (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .tick        (osc_tick),
    .en          (pc_en),
    .debounce_en (pcnt_debounce_en[0]),
    .pin_s       (pcnt_s[0]),
    .match       (pcnt0_match),
    .count_reg   (pcnt0_count),
    .ev_reg      (pc_ev[0])
  );
  pmwc_pulse_counter #(.W(PCNT_W)) u_pc1 (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .tick        (osc_tick),
    .en          (pc_en),
    .debounce_en (pcnt_debounce_en[1]),
    .pin_s       (pcnt_s[1]),
    .match       (pcnt1_match),
    .count_reg   (pcnt1_count),
    .ev_reg      (pc_ev[1])
  );

  // ****************************************
  // wake pending flags
  // ****************************************
  logic [`PMWC_NUM_SRC-1:0] src_ev;
  logic [`PMWC_NUM_SRC-1:0] src_en;
  logic [`PMWC_NUM_SRC-1:0] pend_next;
  logic                     wake_go;
  logic                     deep_go;

  assign src_ev    = {comp_ev, pc_ev, tmr_ev, dio_ev};
  assign src_en    = {comp_wake_en, pcnt_wake_en, timer_wake_en,
                      |dio_wake_en};
  assign pend_next = (wake_pending_reg & ~wake_clr) | src_ev;

  // sticky per source, a new event beats a clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_pending_reg <= `PMWC_PEND_RST;
    end else begin
      wake_pending_reg <= pend_next;
    end
  end

  assign wake_go = |(wake_pending_reg & src_en);
  assign deep_go = |(wake_pending_reg & src_en & `PMWC_DEEP_WAKE_MSK);

  // ****************************************
  // mode state machine
  // ****************************************
  pmwc_state_t               state_next;
  logic [`PMWC_PWR_CNT_W-1:0] pwr_cnt_reg;
  logic [2:0]                cfg_reg;
  logic [2:0]                cfg_next;
  logic                      sleep_entry;
  logic                      deep_entry;

  assign deep_entry  = (state_reg == st_active) && deep_sleep_req;
  assign sleep_entry = (state_reg == st_active) && sleep_req
                       && !deep_sleep_req;

  // mode transitions; the reset pin restarts power-up from anywhere
  always_comb begin
    state_next = state_reg;
    if (!rst_pin_s) begin
      state_next = st_svm;
    end else begin
      case (state_reg)
        st_active: begin
          if (deep_sleep_req) begin
            state_next = st_deep;
          end else if (sleep_req) begin
            state_next = st_sleep;
          end else if (doze_req) begin
            state_next = st_doze;
          end
        end
        st_doze: begin
          if (irq_any) begin
            state_next = st_active;
          end
        end
        st_sleep: begin
          if (wake_go) begin
            state_next = st_svm;
          end
        end
        st_deep: begin
          if (deep_go) begin
            state_next = st_svm;
          end
        end
        st_svm: begin
          if (svm_s) begin
            state_next = st_osc;
          end
        end
        st_osc: begin
          if (hsrc_s) begin
            state_next = st_cpupwr;
          end
        end
        st_cpupwr: begin
          if (pwr_cnt_reg == `PMWC_CPU_PWR_CYC) begin
            state_next = st_active;
          end
        end
        default: state_next = st_svm;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= st_svm;
    end else begin
      state_reg <= state_next;
    end
  end

  // settle count with CPU power on before reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt_reg <= '0;
    end else if (state_reg == st_cpupwr) begin
      pwr_cnt_reg <= pwr_cnt_reg + {{(`PMWC_PWR_CNT_W-1){1'b0}}, 1'b1};
    end else begin
      pwr_cnt_reg <= '0;
    end
  end

  // sleep options latched at entry, digital side is off afterwards
  always_comb begin
    cfg_next = cfg_reg;
    if (!rst_pin_s || deep_entry) begin
      cfg_next = `PMWC_CFG_RST;
    end else if (sleep_entry) begin
      cfg_next = {timers_off_in_sleep, osc_stop_in_sleep, ram_retain_en};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `PMWC_CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // firmware flag: last restart came out of sleep
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reset_from_sleep_reg <= 1'b0;
    end else if (!rst_pin_s) begin
      reset_from_sleep_reg <= 1'b0;
    end else if (state_reg == st_sleep && wake_go) begin
      reset_from_sleep_reg <= 1'b1;
    end else if (state_reg == st_deep && deep_go) begin
      reset_from_sleep_reg <= 1'b0;
    end
  end

  // ****************************************
  // power domain and clock controls
  // ****************************************
  logic ns_run;
  logic ns_slp;
  logic ns_deep;
  logic ns_cpu;
  logic ns_boot;

  assign ns_run  = (state_next == st_active) || (state_next == st_doze);
  assign ns_slp  = (state_next == st_sleep);
  assign ns_deep = (state_next == st_deep);
  assign ns_cpu  = (state_next == st_cpupwr);
  assign ns_boot = (state_next == st_svm) || (state_next == st_osc);

  // outputs follow the next state so they line up with state_reg
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      digital_pwr_en_reg <= 1'b0;
      ram_pwr_en_reg     <= 1'b0;
      radio_pwr_en_reg   <= 1'b0;
      osc32k_run_reg     <= 1'b1;
      timers_pwr_en_reg  <= 1'b1;
      hsrc_en_reg        <= 1'b0;
      cpu_pwr_en_reg     <= 1'b0;
      cpu_reset_n_reg    <= 1'b0;
      cpu_halt_reg       <= 1'b0;
      io_hold_reg        <= 1'b1;
    end else begin
      digital_pwr_en_reg <= ns_run || ns_cpu;
      ram_pwr_en_reg     <= ns_run || ns_cpu || ((ns_slp || ns_boot)
                            && cfg_next[`PMWC_CFG_RETAIN]);
      radio_pwr_en_reg   <= ns_run && radio_req;
      osc32k_run_reg     <= !ns_deep && !(ns_slp
                            && cfg_next[`PMWC_CFG_OSC_STOP]);
      timers_pwr_en_reg  <= !ns_deep && !(ns_slp
                            && cfg_next[`PMWC_CFG_TMR_OFF]);
      hsrc_en_reg        <= ns_run || ns_cpu
                            || (state_next == st_osc);
      cpu_pwr_en_reg     <= ns_run || ns_cpu;
      cpu_reset_n_reg    <= ns_run;
      cpu_halt_reg       <= (state_next == st_doze);
      io_hold_reg        <= !ns_run;
    end
  end

  // IO levels only follow the core while it runs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dio_out_reg <= '0;
      dio_pu_reg  <= '0;
    end else if (ns_run) begin
      dio_out_reg <= dio_out_core;
      dio_pu_reg  <= dio_pu_core;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_doze_cpu_halt: assert property (
    (state_reg == st_doze) |-> cpu_halt_reg && digital_pwr_en_reg
      && cpu_pwr_en_reg && cpu_reset_n_reg)
    else $error("doze state with CPU power wrong");
  a_sleep_dig_off: assert property (
    (state_reg == st_sleep) |-> !digital_pwr_en_reg && !cpu_pwr_en_reg)
    else $error("digital domain on in sleep");
  a_radio_off_slp: assert property (
    (state_reg == st_sleep || state_reg == st_deep) |-> !radio_pwr_en_reg)
    else $error("radio powered in sleep");
  a_ram_retain: assert property (
    (state_reg == st_sleep) |-> (ram_pwr_en_reg == cfg_reg[`PMWC_CFG_RETAIN]))
    else $error("RAM power differs from retention choice");
  a_io_frozen: assert property (
    io_hold_reg |-> $stable(dio_out_reg) && $stable(dio_pu_reg))
    else $error("IO level changed while held");
  a_osc_restart: assert property (
    (state_reg == st_sleep && wake_go && rst_pin_s) |=> osc32k_run_reg
      && (state_reg == st_svm) && reset_from_sleep_reg)
    else $error("slow oscillator not restarted on wake");
  a_no_wake_dis: assert property (
    (state_reg == st_sleep && !wake_go && rst_pin_s) |=> (state_reg == st_sleep))
    else $error("sleep left without enabled wake");
  a_rewake_fast: assert property (
    (sleep_entry && rst_pin_s && |(pend_next & src_en)) ##1 rst_pin_s
      |=> (state_reg == st_svm))
    else $error("pending wake did not rewake");
  a_boot_order: assert property (
    (state_reg == st_cpupwr) |-> hsrc_en_reg && !cpu_reset_n_reg
      && ($past(state_reg) == st_osc || $past(state_reg) == st_cpupwr))
    else $error("restart order broken");
  a_deep_quiet: assert property (
    (state_reg == st_deep) |-> !osc32k_run_reg && !timers_pwr_en_reg
      && !ram_pwr_en_reg)
    else $error("function left running in deep sleep");
  a_deep_exit: assert property (
    (state_reg == st_deep) ##1 (state_reg != st_deep)
      |-> (state_reg == st_svm) && !reset_from_sleep_reg)
    else $error("deep sleep exit not a power-up");
  a_pend_set_win: assert property (
    |(src_ev & wake_clr) |=> ((wake_pending_reg & $past(src_ev))
      == $past(src_ev)))
    else $error("wake event lost to clear");
endmodule // pmwc_top

/* File: verif/pmwc_far_model.sv */
module pmwc_far_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic hsrc_en,
  input  wire logic osc_run,
  output logic      supply_ok,
  output logic      hsrc_stable,
  output logic      osc32k_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] warm_reg;
  logic [1:0] div_reg;
  // supply reads good whenever the part is out of reset
  assign supply_ok = rst_n;
  // fast oscillator settles three cycles after its enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) warm_reg <= 3'h0;
    else warm_reg <= hsrc_en ? {warm_reg[1:0], 1'b1} : 3'h0;
  end
  assign hsrc_stable = warm_reg[2];
  // slow clock stands still while stopped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) div_reg <= 2'h0;
    else if (osc_run) div_reg <= div_reg + 2'h1;
  end
  assign osc32k_clk = div_reg[1];
endmodule // pmwc_far_model

/* File: verif/power_mode_wakeup_controller_tb.sv */
`include "pmwc_cfg.svh"
module power_mode_wakeup_controller_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pmwc_pkg::*;
  logic        mclk, rst_n, external_reset_pin_n, sleep_req, deep_sleep_req;
  logic        doze_req, irq_any, ram_retain_en, osc_stop_in_sleep;
  logic        timers_off_in_sleep, radio_req, supply_ok, hsrc_stable;
  logic        osc32k_clk, comp_in, comp_wake_en, digital_pwr_en_reg;
  logic        ram_pwr_en_reg, radio_pwr_en_reg, osc32k_run_reg;
  logic        timers_pwr_en_reg, hsrc_en_reg, cpu_pwr_en_reg;
  logic        cpu_reset_n_reg, cpu_halt_reg, reset_from_sleep_reg;
  logic        io_hold_reg;
  logic [7:0]  digital_io_pins, dio_wake_en, dio_wake_rise, dio_out_core;
  logic [7:0]  dio_pu_core, dio_out_reg, dio_pu_reg;
  logic [15:0] exp_out;
  logic [1:0]  timer_wake_en, pcnt_in, pcnt_wake_en, pcnt_debounce_en;
  logic [40:0] timer0_cmp, timer1_cmp, timer0_count, timer1_count;
  logic [15:0] pcnt0_match, pcnt1_match, pcnt0_count, pcnt1_count;
  logic [5:0]  wake_clr, wake_pending_reg;
  pmwc_state_t state_reg;
  int          fail_count, tests_run;

  pmwc_top u_dut (.mclk, .rst_n, .external_reset_pin_n, .sleep_req,
    .deep_sleep_req, .doze_req, .irq_any, .ram_retain_en, .osc_stop_in_sleep,
    .timers_off_in_sleep, .radio_req, .supply_ok, .hsrc_stable, .osc32k_clk,
    .digital_io_pins, .dio_wake_en, .dio_wake_rise, .dio_out_core,
    .dio_pu_core, .comp_in, .comp_wake_en, .timer_wake_en, .timer0_cmp,
    .timer1_cmp, .pcnt_in, .pcnt_wake_en, .pcnt_debounce_en, .pcnt0_match,
    .pcnt1_match, .wake_clr, .state_reg, .digital_pwr_en_reg,
    .ram_pwr_en_reg, .radio_pwr_en_reg, .osc32k_run_reg, .timers_pwr_en_reg,
    .hsrc_en_reg, .cpu_pwr_en_reg, .cpu_reset_n_reg, .cpu_halt_reg,
    .reset_from_sleep_reg, .io_hold_reg, .dio_out_reg, .dio_pu_reg,
    .wake_pending_reg, .timer0_count, .timer1_count, .pcnt0_count,
    .pcnt1_count);
  pmwc_far_model u_far (.mclk, .rst_n, .hsrc_en(hsrc_en_reg),
    .osc_run(osc32k_run_reg), .supply_ok, .hsrc_stable, .osc32k_clk);

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for a state, a timeout ends the run
  task automatic wait_st(pmwc_state_t s);
    for (int n = 0; n < 300 && state_reg !== s; n++) cyc(1);
    if (state_reg !== s) begin
      chk("state wait", s, state_reg);
      test_done();
    end
  endtask
  // cpu stays unpowered and in reset until the fast oscillator is up
  always @(negedge mclk) begin
    if (rst_n && (state_reg === st_svm || state_reg === st_osc))
      chk("cpu early", {2'h0, state_reg === st_osc},
        {cpu_pwr_en_reg, cpu_reset_n_reg, hsrc_en_reg});
  end
  // clock source
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h16d1));
    {rst_n, sleep_req, deep_sleep_req, doze_req, irq_any} = 5'h00;
    {ram_retain_en, osc_stop_in_sleep, timers_off_in_sleep} = 3'h0;
    {radio_req, comp_in, pcnt_in, pcnt_debounce_en, wake_clr} = 12'h000;
    {timer_wake_en, pcnt_wake_en, digital_io_pins} = 12'h000;
    {external_reset_pin_n, comp_wake_en} = 2'h3;
    {dio_wake_en, dio_wake_rise, dio_out_core, dio_pu_core} = 32'h0101_0000;
    {timer0_cmp, timer1_cmp} = '1;
    {pcnt0_match, pcnt1_match} = '1;
    {fail_count, tests_run} = 64'h0;
    repeat (8) @(posedge mclk);
    #2 rst_n = 1'b1;
    wait_st(st_active);
    chk("release", 3'h3, {io_hold_reg, cpu_reset_n_reg,
      cpu_pwr_en_reg});
    $display("test power-up done");
    for (int k = 0; k < 3; k++) begin
      {timers_off_in_sleep, ram_retain_en, osc_stop_in_sleep} = 3'($urandom);
      {dio_out_core, dio_pu_core} = 16'($urandom);
      exp_out = {dio_out_core, dio_pu_core};
      dio_wake_rise = ~digital_io_pins;
      radio_req = 1'b1;
      wake_clr = 6'h3f;
      cyc(1);
      wake_clr = 6'h00;
      sleep_req = 1'b1;
      cyc(1);
      sleep_req = 1'b0;
      {dio_out_core, dio_pu_core} = ~exp_out;
      cyc(4);
      chk("sleep st", st_sleep, state_reg);
      chk("domains", {2'h0, ram_retain_en}, {digital_pwr_en_reg,
        radio_pwr_en_reg, ram_pwr_en_reg});
      chk("osc run", {!osc_stop_in_sleep, !timers_off_in_sleep},
        {osc32k_run_reg, timers_pwr_en_reg});
      chk("io held", exp_out, {dio_out_reg, dio_pu_reg});
      digital_io_pins[0] = ~digital_io_pins[0];
      wait_st(st_svm);
      chk("wake", 3'h7, {osc32k_run_reg, reset_from_sleep_reg,
        wake_pending_reg[0]});
      wait_st(st_active);
    end
    $display("test sleep wake done");
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    chk("rewake 1", st_sleep, state_reg);
    cyc(1);
    chk("rewake 2", st_svm, state_reg);
    wait_st(st_active);
    wake_clr = 6'h01;
    cyc(1);
    wake_clr = 6'h00;
    chk("cleared", 6'h00, wake_pending_reg);
    // timer wake, both timers keep running afterwards
    {osc_stop_in_sleep, timers_off_in_sleep, timer_wake_en} = 4'h1;
    timer0_cmp = timer0_count + 41'h8;
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    wait_st(st_svm);
    chk("tmr wake", {6'h02, timer0_cmp},
      {wake_pending_reg, timer0_count});
    wait_st(st_active);
    chk("tmr runs", 2'h3, {timer0_count > timer0_cmp,
      timer1_count == timer0_count});
    // pulse counter wake with the slow oscillator stopped
    {osc_stop_in_sleep, timer_wake_en, pcnt_wake_en} = 5'h11;
    pcnt0_match = pcnt0_count + 16'h2;
    wake_clr = 6'h02;
    cyc(1);
    wake_clr = 6'h00;
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    repeat (6) begin
      pcnt_in = ~pcnt_in;
      cyc(3);
    end
    wait_st(st_active);
    chk("pcnt wake", {6'h08, pcnt0_match + 16'h1, 16'h3},
      {wake_pending_reg, pcnt0_count, pcnt1_count});
    $display("test timer and pulse done");
    {deep_sleep_req, sleep_req} = 2'h3;
    cyc(1);
    {deep_sleep_req, sleep_req} = 2'h0;
    cyc(20);
    chk("deep", {st_deep, 2'h0}, {state_reg, osc32k_run_reg,
      digital_pwr_en_reg});
    comp_in = 1'b1;
    wait_st(st_svm);
    wait_st(st_active);
    chk("deep cause", 6'h28, wake_pending_reg);
    $display("test deep done");
    doze_req = 1'b1;
    cyc(1);
    doze_req = 1'b0;
    cyc(3);
    chk("doze", {st_doze, 3'h7}, {state_reg, cpu_halt_reg,
      digital_pwr_en_reg, radio_pwr_en_reg});
    irq_any = 1'b1;
    cyc(1);
    irq_any = 1'b0;
    chk("doze exit", {st_active, 1'b0}, {state_reg, cpu_halt_reg});
    // pending comparator flag rewakes, then the pin cuts that restart
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    external_reset_pin_n = 1'b0;
    cyc(4);
    chk("pin reset", st_svm, state_reg);
    external_reset_pin_n = 1'b1;
    wait_st(st_active);
    chk("cold", 1'b0, reset_from_sleep_reg);
    $display("test doze and pin done");
    test_done();
  end
endmodule // power_mode_wakeup_controller_tb
